// [rtl/usdp_pkg.sv]
// Constants, register map and carriers for the shadow data port block.
// Assumes a 32-bit APB register bus and byte-wide line-side streams.
package usdp_pkg;

  // ********************************************************************
  // Widths and depths
  // ********************************************************************
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned SLOT_W     = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W      = 4;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned NUM_CHAN   = 2;
  localparam int unsigned CH_RX      = 0;
  localparam int unsigned CH_TX      = 1;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [PTR_W-1:0] PTR_ONE  = 4'h1;

  // ********************************************************************
  // Register byte addresses
  // ********************************************************************
  localparam logic [31:0] ADDR_SLOT_FIRST   = 32'h5000_1030;
  localparam logic [31:0] ADDR_SLOT_LAST    = 32'h5000_106c;
  localparam logic [31:0] ADDR_SLOT5        = 32'h5000_1044;
  localparam logic [31:0] ADDR_FIFO_CONTROL = 32'h5000_1008;
  localparam logic [31:0] ADDR_LINE_STATUS  = 32'h5000_1014;
  localparam logic [31:0] ADDR_INT_STATUS   = 32'h5000_1080;
  localparam logic [31:0] ADDR_INT_MASK     = 32'h5000_1084;

  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int unsigned LS_RDY_BIT  = 0;
  localparam int unsigned LS_OE_BIT   = 1;
  localparam int unsigned LS_TXE_BIT  = 5;
  localparam int unsigned FC_EN_BIT   = 0;
  localparam int unsigned FC_IR_BIT   = 1;
  localparam int unsigned FC_W        = 2;
  localparam int unsigned INT_W       = 3;
  localparam int unsigned INT_RX_BIT  = 0;
  localparam int unsigned INT_OE_BIT  = 1;
  localparam int unsigned INT_TXL_BIT = 2;
  localparam logic [FC_W-1:0]  FC_RESET   = 2'h0;
  localparam logic [INT_W-1:0] INT_RESET  = 3'h0;
  localparam logic [31:0]      WORD_ZERO  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } usdp_byte_t;

endpackage : usdp_pkg

// [rtl/usdp_mem.sv]
// Sixteen-entry byte store for one FIFO, registered read data.
// Assumes the owner keeps addresses in range; same-address write passes.
`timescale 1ns/1ps
module usdp_mem (
  pclk,
  presetn,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input  wire logic                          pclk;
  input  wire logic                          presetn;
  input  wire logic                          we;
  input  wire logic [usdp_pkg::PTR_W-1:0]    waddr;
  input  wire logic [usdp_pkg::DATA_W-1:0]   wdata;
  input  wire logic [usdp_pkg::PTR_W-1:0]    raddr;
  output      logic [usdp_pkg::DATA_W-1:0]   rdata;

  logic [usdp_pkg::DATA_W-1:0] mem_reg [usdp_pkg::FIFO_DEPTH];

  // Storage array; reset so no unknown byte ever reaches a port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < usdp_pkg::FIFO_DEPTH; i++) begin
        mem_reg[i] <= usdp_pkg::BYTE_ZERO;
      end
    end else if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  // Read register with write-through, so a head overwrite shows at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= usdp_pkg::BYTE_ZERO;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem_reg[raddr];
    end
  end

endmodule : usdp_mem

// [rtl/usdp_top.sv]
// Shadow data slot of a UART: receive head and transmit holding path
// behind an APB slave, with FIFO control, line status and interrupts.
// Assumes byte streams from/to serial and infrared framers outside.
//
// Operation
// [RULE_01] All sixteen slot words alias one receive and transmit path.
// [RULE_02] Read low byte comes from serial input, or infrared in IR mode.
// [RULE_03] Read data is valid only while the data-ready flag is set.
// [RULE_04] FIFOs off: new byte overwrites unread byte and flags overrun.
// [RULE_05] FIFOs on: a slot read returns the receive FIFO head.
// [RULE_06] Receive FIFO full: keep contents, drop new byte, flag overrun.
// [RULE_07] Slot writes load transmit path, sent on serial or infrared output.
// [RULE_08] Master writes only while transmit-holding-empty flag is set.
// [RULE_09] FIFOs off: one write clears the transmit-holding-empty flag.
// [RULE_10] FIFOs off: further writes before empty replace the pending byte.
// [RULE_11] FIFOs on: accept writes up to the sixteen-entry depth.
// [RULE_12] Writes while the transmit FIFO is full are dropped.
// [RULE_13] Reserved upper slot bits read zero, writes to them ignored.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module usdp_top (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  uart_rx,
  ir_rx,
  uart_tx,
  uart_tx_ready,
  ir_tx,
  ir_tx_ready,
  irq
);
  input  wire logic                  pclk;
  input  wire logic                  presetn;
  input  wire logic                  psel;
  input  wire logic                  penable;
  input  wire logic                  pwrite;
  input  wire logic [31:0]           paddr;
  input  wire logic [31:0]           pwdata;
  output      logic [31:0]           prdata;
  output      logic                  pready;
  output      logic                  pslverr;
  input  wire usdp_pkg::usdp_byte_t  uart_rx;
  input  wire usdp_pkg::usdp_byte_t  ir_rx;
  output      usdp_pkg::usdp_byte_t  uart_tx;
  input  wire logic                  uart_tx_ready;
  output      usdp_pkg::usdp_byte_t  ir_tx;
  input  wire logic                  ir_tx_ready;
  output      logic                  irq;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [usdp_pkg::FC_W-1:0]   fifo_control_reg;
  logic [usdp_pkg::INT_W-1:0]  int_status_reg;
  logic [usdp_pkg::INT_W-1:0]  int_mask_reg;
  logic                        overrun_reg;
  logic                        rd_valid_reg;
  logic [31:0]                 prdata_reg;
  logic                        pslverr_reg;
  logic                        setup_ph;
  logic                        access_ph;
  logic                        hit_slot;
  logic                        hit_fc;
  logic                        hit_ls;
  logic                        hit_is;
  logic                        hit_im;
  logic                        hit_any;
  logic                        fifo_en;
  logic                        ir_mode;
  logic                        flush;
  logic                        data_ready;
  logic                        tx_empty;
  logic                        tx_ready;
  logic                        rx_overrun;
  logic                        tx_lost;
  logic [31:0]                 ls_word;
  logic [usdp_pkg::INT_W-1:0]  int_set;
  logic [usdp_pkg::INT_W-1:0]  int_clr;
  usdp_pkg::usdp_byte_t        rx_sel;
  logic [usdp_pkg::NUM_CHAN-1:0] push;
  logic [usdp_pkg::NUM_CHAN-1:0] pop;
  logic [usdp_pkg::NUM_CHAN-1:0] full;
  logic [usdp_pkg::NUM_CHAN-1:0] ovw;
  logic [usdp_pkg::NUM_CHAN-1:0] nonempty;
  logic [usdp_pkg::DATA_W-1:0]   wdata [usdp_pkg::NUM_CHAN];
  logic [usdp_pkg::DATA_W-1:0]   head  [usdp_pkg::NUM_CHAN];

  // ********************************************************************
  // APB decode
  // ********************************************************************
  // Zero wait states: every access completes in its first access cycle
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign pready    = 1'b1;
  assign prdata    = prdata_reg;
  assign pslverr   = pslverr_reg;

  // Any aligned word of the sixteen-slot window is the same slot
  assign hit_slot = (paddr >= usdp_pkg::ADDR_SLOT_FIRST) &&
                    (paddr <= usdp_pkg::ADDR_SLOT_LAST) &&
                    (paddr[1:0] == 2'h0); // RULE_01
  assign hit_fc   = (paddr == usdp_pkg::ADDR_FIFO_CONTROL);
  assign hit_ls   = (paddr == usdp_pkg::ADDR_LINE_STATUS);
  assign hit_is   = (paddr == usdp_pkg::ADDR_INT_STATUS);
  assign hit_im   = (paddr == usdp_pkg::ADDR_INT_MASK);
  assign hit_any  = hit_slot || hit_fc || hit_ls || hit_is || hit_im;

  assign fifo_en  = fifo_control_reg[usdp_pkg::FC_EN_BIT];
  assign ir_mode  = fifo_control_reg[usdp_pkg::FC_IR_BIT];

  // ********************************************************************
  // Control registers
  // ********************************************************************
  // Changing the FIFO enable empties both paths, as stale depth is unsafe
  assign flush = access_ph && pwrite && hit_fc &&
                 (pwdata[usdp_pkg::FC_EN_BIT] != fifo_en);

  // FIFO control: enable and infrared mode select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_control_reg <= usdp_pkg::FC_RESET;
    end else if (access_ph && pwrite && hit_fc) begin
      fifo_control_reg <= pwdata[usdp_pkg::FC_W-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= usdp_pkg::INT_RESET;
    end else if (access_ph && pwrite && hit_im) begin
      int_mask_reg <= pwdata[usdp_pkg::INT_W-1:0];
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  assign int_clr = (access_ph && pwrite && hit_is) ?
                   pwdata[usdp_pkg::INT_W-1:0] : usdp_pkg::INT_RESET;
  always_comb begin
    int_set = usdp_pkg::INT_RESET;
    int_set[usdp_pkg::INT_RX_BIT]  = push[usdp_pkg::CH_RX];
    int_set[usdp_pkg::INT_OE_BIT]  = rx_overrun;
    int_set[usdp_pkg::INT_TXL_BIT] = tx_lost;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= usdp_pkg::INT_RESET;
    end else begin
      int_status_reg <= int_set | (int_status_reg & ~int_clr);
    end
  end

  // Level interrupt while any unmasked event stands
  assign irq = |(int_status_reg & int_mask_reg);

  // Line status overrun: cleared by reading line status, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_reg <= 1'b0;
    end else if (rx_overrun) begin
      overrun_reg <= 1'b1; // RULE_04 RULE_06
    end else if (access_ph && !pwrite && hit_ls) begin
      overrun_reg <= 1'b0;
    end
  end

  // ********************************************************************
  // Line side steering
  // ********************************************************************
  // Receive source follows the mode bit
  assign rx_sel = ir_mode ? ir_rx : uart_rx; // RULE_02
  assign push[usdp_pkg::CH_RX]  = rx_sel.valid;
  assign wdata[usdp_pkg::CH_RX] = rx_sel.data;

  // Full FIFO keeps its contents; unread byte with FIFOs off is replaced
  assign rx_overrun = rx_sel.valid &&
                      (full[usdp_pkg::CH_RX] ||
                       ovw[usdp_pkg::CH_RX]); // RULE_04 RULE_06

  // Slot writes feed the transmit path; upper bits are dropped
  assign push[usdp_pkg::CH_TX] = access_ph && pwrite && hit_slot; // RULE_07
  assign wdata[usdp_pkg::CH_TX] = pwdata[usdp_pkg::DATA_W-1:0]; // RULE_13
  assign tx_lost = push[usdp_pkg::CH_TX] && full[usdp_pkg::CH_TX]; // RULE_12

  // Transmit byte goes to the active output only
  assign tx_ready = ir_mode ? ir_tx_ready : uart_tx_ready;
  assign pop[usdp_pkg::CH_TX] = tx_ready && nonempty[usdp_pkg::CH_TX];
  assign uart_tx.valid = !ir_mode && nonempty[usdp_pkg::CH_TX]; // RULE_07
  assign uart_tx.data  = head[usdp_pkg::CH_TX];
  assign ir_tx.valid   = ir_mode && nonempty[usdp_pkg::CH_TX]; // RULE_07
  assign ir_tx.data    = head[usdp_pkg::CH_TX];

  // Receive head is consumed only by a slot read that saw valid data
  assign pop[usdp_pkg::CH_RX] = access_ph && !pwrite && hit_slot &&
                                rd_valid_reg; // RULE_05

  assign data_ready = nonempty[usdp_pkg::CH_RX]; // RULE_03
  assign tx_empty   = !nonempty[usdp_pkg::CH_TX]; // RULE_09

  // ********************************************************************
  // Byte queues: receive and transmit share one structure
  // ********************************************************************
  // With FIFOs off a queue holds one byte and a push onto a held byte
  // overwrites it in place; this costs nothing over a separate holding reg
  for (genvar c = 0; c < usdp_pkg::NUM_CHAN; c++) begin : g_chan
    logic [usdp_pkg::CNT_W-1:0] count_reg;
    logic [usdp_pkg::PTR_W-1:0] wr_ptr_reg;
    logic [usdp_pkg::PTR_W-1:0] rd_ptr_reg;
    logic                       do_push;
    logic                       do_pop;
    logic                       advance;
    logic [usdp_pkg::PTR_W-1:0] waddr;
    logic [usdp_pkg::PTR_W-1:0] raddr;

    assign nonempty[c] = (count_reg != usdp_pkg::CNT_ZERO);
    assign full[c]     = fifo_en &&
                         (count_reg == usdp_pkg::CNT_FULL); // RULE_11
    assign ovw[c]      = !fifo_en && nonempty[c] &&
                         !pop[c]; // RULE_04 RULE_10
    assign do_push     = push[c] && !full[c]; // RULE_06 RULE_12
    assign do_pop      = pop[c] && nonempty[c];
    assign advance     = do_push && !ovw[c];
    assign waddr       = ovw[c] ? rd_ptr_reg : wr_ptr_reg;
    assign raddr       = do_pop ? (rd_ptr_reg + usdp_pkg::PTR_ONE)
                                : rd_ptr_reg;

    // Pointers and fill level
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        count_reg  <= usdp_pkg::CNT_ZERO;
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else if (flush) begin
        count_reg  <= usdp_pkg::CNT_ZERO;
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else begin
        if (advance) begin
          wr_ptr_reg <= wr_ptr_reg + usdp_pkg::PTR_ONE;
        end
        if (do_pop) begin
          rd_ptr_reg <= rd_ptr_reg + usdp_pkg::PTR_ONE;
        end
        if (advance && !do_pop) begin
          count_reg <= count_reg + 5'h01;
        end else if (do_pop && !advance) begin
          count_reg <= count_reg - 5'h01;
        end
      end
    end

    usdp_mem u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (do_push && !flush),
      .waddr   (waddr),
      .wdata   (wdata[c]),
      .raddr   (flush ? usdp_pkg::PTR_W'(0) : raddr),
      .rdata   (head[c])
    );
  end

  // ********************************************************************
  // Read data
  // ********************************************************************
  // Line status word
  always_comb begin
    ls_word = usdp_pkg::WORD_ZERO;
    ls_word[usdp_pkg::LS_RDY_BIT] = data_ready;
    ls_word[usdp_pkg::LS_OE_BIT]  = overrun_reg;
    ls_word[usdp_pkg::LS_TXE_BIT] = tx_empty;
  end

  // Captured in the setup cycle; the head cannot leave before the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg   <= usdp_pkg::WORD_ZERO;
      pslverr_reg  <= 1'b0;
      rd_valid_reg <= 1'b0;
    end else if (setup_ph) begin
      pslverr_reg  <= !hit_any;
      rd_valid_reg <= hit_slot && data_ready; // RULE_03
      prdata_reg   <= usdp_pkg::WORD_ZERO; // RULE_13
      if (!pwrite) begin
        unique case (1'b1)
          hit_slot: prdata_reg[usdp_pkg::DATA_W-1:0] <=
                      data_ready ? head[usdp_pkg::CH_RX]
                                 : usdp_pkg::BYTE_ZERO; // RULE_05
          hit_fc:   prdata_reg[usdp_pkg::FC_W-1:0] <= fifo_control_reg;
          hit_ls:   prdata_reg <= ls_word;
          hit_is:   prdata_reg[usdp_pkg::INT_W-1:0] <= int_status_reg;
          hit_im:   prdata_reg[usdp_pkg::INT_W-1:0] <= int_mask_reg;
          default:  prdata_reg <= usdp_pkg::WORD_ZERO;
        endcase
      end
    end
  end

endmodule : usdp_top

// [verification/usdp_top_asserts.sv]
// Checker for the shadow data port, bound to usdp_top.
// Sees only the top ports; keeps its own copy of the IR mode bit.
`timescale 1ns/1ps
module usdp_top_asserts (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire usdp_pkg::usdp_byte_t uart_rx,
  input wire usdp_pkg::usdp_byte_t ir_rx,
  input wire usdp_pkg::usdp_byte_t uart_tx,
  input wire logic                 uart_tx_ready,
  input wire usdp_pkg::usdp_byte_t ir_tx,
  input wire logic                 ir_tx_ready,
  input wire logic                 irq
);
  // ****
  // Decode helpers
  // ****
  logic setup, wr, slot, mapped, ir_q;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign slot = paddr >= usdp_pkg::ADDR_SLOT_FIRST &&
                paddr <= usdp_pkg::ADDR_SLOT_LAST;
  assign mapped = slot || paddr == usdp_pkg::ADDR_FIFO_CONTROL ||
                  paddr == usdp_pkg::ADDR_LINE_STATUS ||
                  paddr == usdp_pkg::ADDR_INT_STATUS ||
                  paddr == usdp_pkg::ADDR_INT_MASK;
  // Mode shadow, so the active transmit path is known here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ir_q <= 1'b0;
    else if (wr && paddr == usdp_pkg::ADDR_FIFO_CONTROL)
      ir_q <= pwdata[usdp_pkg::FC_IR_BIT];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // Properties
  // ****
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access not ready");
  a_decode_err: assert property (
    setup && paddr[1:0] == 2'h0 |=> pslverr == !mapped)
    else $error("error response wrong for address");
  a_unmapped_zero: assert property (
    setup && !mapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_slot_upper: assert property (
    setup && slot |=> prdata[31:8] == 24'h0)
    else $error("slot upper bits not zero");
  a_write_uart: assert property (
    wr && slot && !ir_q |=> uart_tx.valid)
    else $error("slot write not on serial path");
  a_write_ir: assert property (
    wr && slot && ir_q |=> ir_tx.valid)
    else $error("slot write not on infrared path");
  a_path_select: assert property (
    ir_q ? !uart_tx.valid : !ir_tx.valid)
    else $error("inactive path offers a byte");
  // A stalled serial byte stays put unless software touches the block
  a_tx_hold: assert property (
    uart_tx.valid && !uart_tx_ready && !wr |=> $stable(uart_tx))
    else $error("stalled byte changed");
  a_mask_quiets: assert property (wr && pwdata[2:0] == 3'h0 &&
    paddr == usdp_pkg::ADDR_INT_MASK |=> !irq)
    else $error("irq with all masked");
  c_ir_write: cover property (wr && slot && ir_q);
  c_stall: cover property (uart_tx.valid && !uart_tx_ready);
  c_irq: cover property (irq);
endmodule : usdp_top_asserts

bind usdp_top usdp_top_asserts usdp_top_asserts_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .uart_rx(uart_rx), .ir_rx(ir_rx),
  .uart_tx(uart_tx), .uart_tx_ready(uart_tx_ready), .ir_tx(ir_tx),
  .ir_tx_ready(ir_tx_ready), .irq(irq));

// [verification/usdp_line_model.sv]
// Far-side model: serial and infrared framers of the remote end.
// Assumes the bench calls send and sets stall between edges.
`timescale 1ns/1ps
module usdp_line_model (
  input wire logic                 pclk,
  output     usdp_pkg::usdp_byte_t uart_rx,
  output     usdp_pkg::usdp_byte_t ir_rx,
  input wire usdp_pkg::usdp_byte_t uart_tx,
  input wire usdp_pkg::usdp_byte_t ir_tx,
  output     logic                 uart_tx_ready,
  output     logic                 ir_tx_ready
);
  logic       stall;
  logic [7:0] got[$];
  initial begin
    stall = 1'b1;
    uart_rx = '0;
    ir_rx = '0;
    uart_tx_ready = 1'b0;
    ir_tx_ready = 1'b0;
  end
  // One-cycle pulse; idle data shows the inverse so stale bytes differ
  task automatic send(input logic ir, input logic [7:0] d);
    @(posedge pclk);
    if (ir) ir_rx <= {1'b1, d};
    else uart_rx <= {1'b1, d};
    @(posedge pclk);
    if (ir) ir_rx <= {1'b0, ~d};
    else uart_rx <= {1'b0, ~d};
  endtask : send
  // Ready lags stall by a cycle, so the design meets a slow taker too
  always @(posedge pclk) begin
    if (uart_tx.valid && uart_tx_ready) got.push_back(uart_tx.data);
    if (ir_tx.valid && ir_tx_ready) got.push_back(ir_tx.data);
    uart_tx_ready <= !stall;
    ir_tx_ready <= !stall;
  end
endmodule : usdp_line_model

// [verification/uart_shadow_data_port_test.sv]
// Self-checking bench for usdp_top with the line model as far side.
// Assumes an APB slave that may stretch accesses; waits are bounded.
`timescale 1ns/1ps
module uart_shadow_data_port_test;
  localparam logic [31:0] S5 = usdp_pkg::ADDR_SLOT5;
  localparam logic [31:0] LS = usdp_pkg::ADDR_LINE_STATUS;
  localparam logic [31:0] FC = usdp_pkg::ADDR_FIFO_CONTROL;
  localparam logic [31:0] IS = usdp_pkg::ADDR_INT_STATUS;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, uart_tx_ready, ir_tx_ready, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  usdp_pkg::usdp_byte_t uart_rx, ir_rx, uart_tx, ir_tx;
  int          mismatches, comparisons, i;
  usdp_top usdp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uart_rx(uart_rx), .ir_rx(ir_rx), .uart_tx(uart_tx),
    .uart_tx_ready(uart_tx_ready), .ir_tx(ir_tx),
    .ir_tx_ready(ir_tx_ready), .irq(irq));
  usdp_line_model usdp_line_model_i (.pclk(pclk), .uart_rx(uart_rx),
    .ir_rx(ir_rx), .uart_tx(uart_tx), .ir_tx(ir_tx),
    .uart_tx_ready(uart_tx_ready), .ir_tx_ready(ir_tx_ready));
  // ****
  // Shared tasks
  // ****
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic hang;
    mismatches++;
    wrap_up();
  endtask : hang
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; idle cycle first so psel is never set twice at once
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string n, input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdc
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (usdp_line_model_i.got.size() < k && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (usdp_line_model_i.got.size() < k) hang();
  endtask : wait_got
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rdc("slot reset", S5, 32'h0);
    rdc("status reset", LS, 32'h20);
    rdc("unmapped data", 32'h5000_1100, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
  endtask : t_reset
  task automatic t_rx;
    usdp_line_model_i.send(1'b0, 8'h5a);
    usdp_line_model_i.send(1'b0, 8'ha5);
    usdp_line_model_i.send(1'b1, 8'hc3);
    rdc("overrun", LS, 32'h23);
    rdc("alias read", usdp_pkg::ADDR_SLOT_FIRST, 32'ha5);
    rdc("not ready", LS, 32'h20);
    rdc("empty read", S5, 32'h0);
    apb(1'b1, FC, 32'h1);
    for (i = 0; i < 17; i++) usdp_line_model_i.send(1'b0, 8'(i + 16));
    rdc("fifo overrun", LS, 32'h23);
    for (i = 0; i < 16; i++) rdc("head",
      usdp_pkg::ADDR_SLOT_FIRST + 32'(4 * i), 32'(i + 16));
    rdc("drop extra", S5, 32'h0);
    apb(1'b1, FC, 32'h3);
    usdp_line_model_i.send(1'b0, 8'h99);
    usdp_line_model_i.send(1'b1, 8'h3c);
    rdc("ir byte", S5, 32'h3c);
    rdc("serial ignored", LS, 32'h20);
  endtask : t_rx
  task automatic t_tx_plain;
    apb(1'b1, FC, 32'h0);
    rdc("holding free", LS, 32'h20);
    apb(1'b1, S5, 32'h11);
    rdc("holding busy", LS, 32'h0);
    apb(1'b1, S5, 32'h22);
    apb(1'b1, S5, 32'hffff_ff33);
    usdp_line_model_i.stall <= 1'b0;
    wait_got(1);
    rdc("holding empty", LS, 32'h20);
    chk("sent count", 32'h1, 32'(usdp_line_model_i.got.size()));
    chk("sent byte", 32'h33, {24'h0, usdp_line_model_i.got[0]});
  endtask : t_tx_plain
  task automatic t_tx_fifo;
    usdp_line_model_i.stall <= 1'b1;
    usdp_line_model_i.got.delete();
    apb(1'b1, FC, 32'h1);
    rdc("rx events", IS, 32'h3);
    apb(1'b1, IS, 32'h7);
    apb(1'b1, usdp_pkg::ADDR_INT_MASK, 32'h0);
    for (i = 0; i < 17; i++) apb(1'b1, S5, 32'(i + 64));
    rdc("lost flag", IS, 32'h4);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, usdp_pkg::ADDR_INT_MASK, 32'h4);
    rdc("mask", usdp_pkg::ADDR_INT_MASK, 32'h4);
    chk("irq raised", 32'h1, {31'h0, irq});
    usdp_line_model_i.stall <= 1'b0;
    wait_got(16);
    rdc("fifo empty", LS, 32'h20);
    chk("fifo count", 32'd16, 32'(usdp_line_model_i.got.size()));
    for (i = 0; i < 16; i++) chk("fifo byte", 32'(i + 64),
      {24'h0, usdp_line_model_i.got[i]});
    apb(1'b1, IS, 32'h4);
    rdc("cleared", IS, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    usdp_line_model_i.got.delete();
    apb(1'b1, FC, 32'h3);
    apb(1'b1, S5, 32'h77);
    wait_got(1);
    chk("ir sent", 32'h77, {24'h0, usdp_line_model_i.got[0]});
  endtask : t_tx_fifo
  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rx();
    t_tx_plain();
    t_tx_fifo();
    wrap_up();
  end
endmodule : uart_shadow_data_port_test
